// [verilog/rops_regs.svh]
`ifndef ROPS_REGS_SVH
`define ROPS_REGS_SVH

// Register indices (word offsets on the plain register port)
`define ROPS_SEL_8_9_IDX    3'h0
`define ROPS_SEL_10_11_IDX  3'h1
`define ROPS_SEL_12_13_IDX  3'h2
`define ROPS_SEL_14_15_IDX  3'h3
`define ROPS_SEL_16_17_IDX  3'h4
`define ROPS_SEL_18_19_IDX  3'h5
`define ROPS_SEL_20_21_IDX  3'h6
`define ROPS_NUM_REGS       7

// Field positions
`define ROPS_ODD_LSB        8
`define ROPS_EVEN_LSB       0
`define ROPS_FIELD_W        6

// Reset value of every mapping field
`define ROPS_FIELD_RESET    6'h00

// Remappable pin range and the pin absent in the smallest package
`define ROPS_FIRST_PIN      8
`define ROPS_NUM_PINS       14
`define ROPS_ABSENT_PIN     15

// Peripheral output functions: numbers 1..ROPS_NUM_FUNCS are defined
`define ROPS_NUM_FUNCS      63

`endif

// [verilog/rops_pkg.sv]
`include "rops_regs.svh"

package rops_pkg;

  typedef logic [`ROPS_FIELD_W-1:0] rops_sel_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } rops_bus_req_t;

endpackage

// [verilog/rops_top.sv]
// The implementer's own choices: the address-and-strobe port and the register offsets.
`include "rops_regs.svh"

// Operation
// - Pin outputs the function its field selects
// - Odd pin field at bits 13-8, read/write
// - Even pin field at bits 5-0, read/write
// - Bits 15-14, 7-6 ignore writes, read zero
// - All mapping fields clear at reset
// - Pin 15 field absent in small package
module rops_top
  import rops_pkg::*;
(
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         small_pkg_i,
  input  wire rops_bus_req_t                bus_req_i,
  output logic [15:0]                       rdata_o,
  input  wire logic [`ROPS_NUM_FUNCS:1]     func_out_i,
  output logic [`ROPS_NUM_PINS-1:0]         pin_out_o,
  output logic [`ROPS_NUM_PINS-1:0]         pin_remapped_o
);

  rops_sel_t   sel      [`ROPS_NUM_PINS];
  rops_sel_t   next_sel [`ROPS_NUM_PINS];
  logic [15:0] next_rdata;
  logic [15:0] rd_word;

  // Index of the pin whose field is absent in the smallest package
  localparam int ABSENT_IDX = `ROPS_ABSENT_PIN - `ROPS_FIRST_PIN;

  // Register write path: pin 8+k lives in register k/2, odd pins high
  always_comb begin
    for (int k = 0; k < `ROPS_NUM_PINS; k++) begin
      next_sel[k] = sel[k];
      if (bus_req_i.wr && bus_req_i.addr == 3'(k / 2)) begin
        if (k % 2 == 1) begin
          next_sel[k] = bus_req_i.wdata[`ROPS_ODD_LSB +: `ROPS_FIELD_W];
        end else begin
          next_sel[k] = bus_req_i.wdata[`ROPS_EVEN_LSB +: `ROPS_FIELD_W];
        end
      end
      if (small_pkg_i && k == `ROPS_ABSENT_PIN - `ROPS_FIRST_PIN) begin
        next_sel[k] = `ROPS_FIELD_RESET;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int k = 0; k < `ROPS_NUM_PINS; k++) begin
        sel[k] <= `ROPS_FIELD_RESET;
      end
    end else begin
      sel <= next_sel;
    end
  end

  // Read path: unused bits and unmapped addresses read zero
  always_comb begin
    rd_word = 16'h0000;
    for (int r = 0; r < `ROPS_NUM_REGS; r++) begin
      if (bus_req_i.addr == 3'(r)) begin
        rd_word[`ROPS_EVEN_LSB +: `ROPS_FIELD_W] = sel[2*r];
        rd_word[`ROPS_ODD_LSB +: `ROPS_FIELD_W]  = sel[2*r+1];
      end
    end
    next_rdata = bus_req_i.rd ? rd_word : rdata_o;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Output muxes, one per remappable pin
  genvar g;
  generate
    for (g = 0; g < `ROPS_NUM_PINS; g++) begin : g_pin
      logic hit;
      logic val;
      always_comb begin
        hit = 1'b0;
        val = 1'b0;
        for (int f = 1; f <= `ROPS_NUM_FUNCS; f++) begin
          if (sel[g] == 6'(f)) begin
            hit = 1'b1;
            val = func_out_i[f];
          end
        end
      end
      assign pin_remapped_o[g] = hit;
      assign pin_out_o[g]      = hit & val;

      property p_pin_route;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (sel[g] != 6'h00) |-> (pin_out_o[g] == func_out_i[sel[g]]);
      endproperty
      a_pin_route: assert property (p_pin_route)
        else $error("pin does not carry selected function");

      property p_zero_idle;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (sel[g] == 6'h00) |-> (!pin_remapped_o[g] && !pin_out_o[g]);
      endproperty
      a_zero_idle: assert property (p_zero_idle)
        else $error("unselected pin is driven");

      // Field position of this pin within its register
      localparam int FLD_LSB = (g % 2 == 1) ? `ROPS_ODD_LSB
                                            : `ROPS_EVEN_LSB;

      property p_field_write;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.wr && bus_req_i.addr == 3'(g / 2)
          && !(small_pkg_i && g == ABSENT_IDX))
          |=> (sel[g] == $past(bus_req_i.wdata[FLD_LSB +: `ROPS_FIELD_W]));
      endproperty
      a_field_write: assert property (p_field_write)
        else $error("field does not take the written value");

      property p_field_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (!(bus_req_i.wr && bus_req_i.addr == 3'(g / 2))
          && !(small_pkg_i && g == ABSENT_IDX)) |=> $stable(sel[g]);
      endproperty
      a_field_hold: assert property (p_field_hold)
        else $error("field changed without a write");

      property p_remap_flag;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        pin_remapped_o[g] == (sel[g] != 6'h00);
      endproperty
      a_remap_flag: assert property (p_remap_flag)
        else $error("remap flag disagrees with field");

      property p_out_gate;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !pin_remapped_o[g] |-> !pin_out_o[g];
      endproperty
      a_out_gate: assert property (p_out_gate)
        else $error("pin driven while under port control");

      property p_route_high;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (sel[g] != 6'h00 && func_out_i[sel[g]]) |-> pin_out_o[g];
      endproperty
      a_route_high: assert property (p_route_high)
        else $error("pin low while selected function is high");

      property p_route_low;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (sel[g] != 6'h00 && !func_out_i[sel[g]]) |-> !pin_out_o[g];
      endproperty
      a_route_low: assert property (p_route_low)
        else $error("pin high while selected function is low");

      property p_reset_field;
        @(posedge ref_clk_i)
        $rose(rst_b_i) |-> (sel[g] == 6'h00);
      endproperty
      a_reset_field: assert property (p_reset_field)
        else $error("field not zero after reset");

      property p_reset_route;
        @(posedge ref_clk_i)
        $rose(rst_b_i) |-> !pin_remapped_o[g];
      endproperty
      a_reset_route: assert property (p_reset_route)
        else $error("pin remapped right after reset");
    end
  endgenerate

  property p_odd_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_req_i.wr && bus_req_i.addr == 3'h0)
      |=> (sel[1] == $past(bus_req_i.wdata[13:8]));
  endproperty
  a_odd_write: assert property (p_odd_write)
    else $error("odd field not written from bits 13-8");

  property p_even_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_req_i.wr && bus_req_i.addr == 3'h6)
      |=> (sel[12] == $past(bus_req_i.wdata[5:0]));
  endproperty
  a_even_write: assert property (p_even_write)
    else $error("even field not written from bits 5-0");

  property p_reserved_zero;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    bus_req_i.rd |=> (rdata_o[15:14] == 2'b00 && rdata_o[7:6] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_readback;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_req_i.rd && bus_req_i.addr == 3'h2)
      |=> (rdata_o == {2'b00, $past(sel[5]), 2'b00, $past(sel[4])});
  endproperty
  a_readback: assert property (p_readback)
    else $error("read data does not match fields");

  property p_absent_pin;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    $past(small_pkg_i) |-> (sel[7] == 6'h00);
  endproperty
  a_absent_pin: assert property (p_absent_pin)
    else $error("absent pin field holds a value");

  property p_reset_clear;
    @(posedge ref_clk_i)
    $rose(rst_b_i) |-> (sel[0] == 6'h00 && sel[13] == 6'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("field not cleared by reset");

  // Per-register read checks
  genvar gr;
  generate
    for (gr = 0; gr < `ROPS_NUM_REGS; gr++) begin : g_reg
      property p_reg_read;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.rd && bus_req_i.addr == 3'(gr))
          |=> (rdata_o == {2'b00, $past(sel[2*gr+1]),
                           2'b00, $past(sel[2*gr])});
      endproperty
      a_reg_read: assert property (p_reg_read)
        else $error("register read does not return its fields");

      property p_reg_reserved;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.rd && bus_req_i.addr == 3'(gr))
          |=> (rdata_o[15:14] == 2'b00 && rdata_o[7:6] == 2'b00);
      endproperty
      a_reg_reserved: assert property (p_reg_reserved)
        else $error("unimplemented bits read nonzero");
    end
  endgenerate

  property p_rdata_hold;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !bus_req_i.rd |=> $stable(rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_write_keeps_rdata;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    bus_req_i.wr |=> $stable(rdata_o);
  endproperty
  a_write_keeps_rdata: assert property (p_write_keeps_rdata)
    else $error("write disturbed read data");

  property p_unmapped_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_req_i.rd && bus_req_i.addr == 3'h7) |=> (rdata_o == 16'h0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped address read nonzero");

  property p_unmapped_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_req_i.wr && bus_req_i.addr == 3'h7)
      |=> ($stable(sel[0]) && $stable(sel[13]));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write changed a field");

  property p_reset_rdata;
    @(posedge ref_clk_i)
    $rose(rst_b_i) |-> (rdata_o == 16'h0000);
  endproperty
  a_reset_rdata: assert property (p_reset_rdata)
    else $error("read data not zero after reset");

  property p_absent_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_req_i.rd && bus_req_i.addr == 3'h3
      && small_pkg_i && $past(small_pkg_i)) |=> (rdata_o[13:8] == 6'h00);
  endproperty
  a_absent_read: assert property (p_absent_read)
    else $error("absent field read nonzero");

  property p_absent_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (small_pkg_i && bus_req_i.wr && bus_req_i.addr == 3'h3)
      |=> (sel[ABSENT_IDX] == 6'h00);
  endproperty
  a_absent_write: assert property (p_absent_write)
    else $error("absent field took a write");

  property p_absent_idle;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (small_pkg_i && $past(small_pkg_i))
      |-> (!pin_remapped_o[ABSENT_IDX] && !pin_out_o[ABSENT_IDX]);
  endproperty
  a_absent_idle: assert property (p_absent_idle)
    else $error("absent pin is driven");

endmodule

// [bench/rops_func_model.sv]
module rops_func_model
  import rops_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  output logic [63:1]      func_out_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Rotating uneven pattern exposes a pin tied to a wrong function not a multiple of 7 away
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      func_out_o <= {9{7'b1101000}};
    end else begin
      func_out_o <= {func_out_o[62:1], func_out_o[63]};
    end
  end
endmodule

// [bench/rops_top_bench.sv]
module rops_top_bench;
  import rops_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic          ref_clk_i = 0;
  logic          rst_b_i = 0;
  logic          small_pkg = 0;
  rops_bus_req_t q = '0;
  logic [15:0]   rdata;
  logic [63:1]   func;
  logic [13:0]   pin_out;
  logic [13:0]   pin_rem;
  int            failures = 0;
  int            checks = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  rops_top rops_top_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .small_pkg_i(small_pkg), .bus_req_i(q), .rdata_o(rdata),
    .func_out_i(func), .pin_out_o(pin_out), .pin_remapped_o(pin_rem));
  rops_func_model rops_func_model_i (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .func_out_o(func));
  task cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_pin(input logic [13:0] got, input logic [13:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk_i) q <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk_i) q.wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge ref_clk_i) q <= '{1'b0, 1'b1, a, 16'h0};
    @(posedge ref_clk_i) q.rd <= 1'b0;
    #1 cmp_reg(rdata, e);
  endtask
  task tally_and_finish;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #5000 failures++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i), 16'h0);
    cmp_pin(pin_rem, 14'h0);
    $display("test reset values done");
    for (int i = 0; i < 7; i++) begin
      wr(3'(i), 16'hffff);
      rd(3'(i), 16'h3f3f);
    end
    $display("test field bits done");
    for (int i = 0; i < 7; i++) begin
      wr(3'(i), 16'(16'hc0c0 | i * 514 + 513));
    end
    for (int i = 0; i < 7; i++) rd(3'(i), 16'(i * 514 + 513));
    cmp_pin(pin_rem, 14'h3fff);
    cmp_pin(pin_out, func[14:1]);
    $display("test routing done");
    @(posedge ref_clk_i) small_pkg <= 1'b1;
    rd(3'h3, 16'h0007);
    cmp_pin(pin_rem, 14'h3f7f);
    cmp_pin(pin_out & 14'h0080, 14'h0);
    $display("test small package done");
    @(posedge ref_clk_i) small_pkg <= 1'b0;
    wr(3'h0, 16'h0);
    cmp_pin(pin_rem & 14'h3, 14'h0);
    cmp_pin(pin_out & 14'h3, 14'h0);
    $display("test zero selection done");
    @(posedge ref_clk_i) rst_b_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(3'h5, 16'h0);
    cmp_pin(pin_rem, 14'h0);
    $display("test mid-run reset done");
    tally_and_finish;
  end
endmodule
